// [design/lpsc_pkg.sv]
`default_nettype none
package lpsc_pkg;
  // instruction encodings (upper bits compared under mask)
  localparam logic [7:0] OP_DISP_ONOFF  = 8'hAE;
  localparam logic [7:0] OP_DISP_MASK   = 8'hFE;
  localparam logic [7:0] OP_WHOLE_ONOFF = 8'hA4;
  localparam logic [7:0] OP_WHOLE_MASK  = 8'hFE;
  localparam logic [7:0] OP_COL_ORDER   = 8'hA0;
  localparam logic [7:0] OP_COL_MASK    = 8'hFE;
  localparam logic [7:0] OP_DRIVE       = 8'h22;
  localparam logic [7:0] OP_DRIVE_MASK  = 8'hFE;
  localparam logic [7:0] OP_SUPPLY      = 8'h24;
  localparam logic [7:0] OP_SUPPLY_MASK = 8'hFE;
  // contrast register
  localparam logic [7:0] CONTRAST_RESET = 8'hFF;
  localparam logic [8:0] LEVEL_FULL     = 9'h12C;
  localparam logic [8:0] LEVEL_OFFSET   = 9'h02D;
  localparam logic [7:0] CONTRAST_MIN   = 8'h37;
  // serial word length
  localparam int unsigned SER_BITS = 8;
endpackage : lpsc_pkg
`default_nettype wire

// [design/lpsc_serial_rx.sv]
`default_nettype none
module lpsc_serial_rx #(
  parameter int unsigned BITS = lpsc_pkg::SER_BITS
) (
  input  wire logic            clock_in,
  input  wire logic            rst_n_in,
  input  wire logic            sel_n_in,
  input  wire logic            sck_rise_in,
  input  wire logic            sdi_in,
  input  wire logic            cds_in,
  output logic                 strobe_out,
  output logic                 cds_out,
  output logic [BITS-1:0]      data_out
);
  logic [BITS-1:0]         shift_q;
  logic [$clog2(BITS)-1:0] count_q;

  // msb first, word and command/data flag taken at the last rising edge
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q    <= '0;
      count_q    <= '0;
      strobe_out <= 1'b0;
      cds_out    <= 1'b0;
      data_out   <= '0;
    end else begin
      strobe_out <= 1'b0;
      if (sel_n_in) begin
        shift_q <= '0;
        count_q <= '0;
      end else if (sck_rise_in) begin
        shift_q <= {shift_q[BITS-2:0], sdi_in};
        count_q <= count_q + 1'b1;
        if (count_q == ($clog2(BITS))'(BITS - 1)) begin
          strobe_out <= 1'b1;
          cds_out    <= cds_in;
          data_out   <= {shift_q[BITS-2:0], sdi_in};
        end
      end
    end
  end
endmodule : lpsc_serial_rx
`default_nettype wire

// [design/lpsc_contrast.sv]
`default_nettype none
module lpsc_contrast (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] contrast_level_in,
  input  wire logic       supply_mode_pin_a_in,
  input  wire logic       supply_mode_pin_b_in,
  input  wire logic       supply_on_in,
  output logic [8:0]      ref_level_out,
  output logic            adjust_active_out
);
  // code ff gives 300/300, each lower code one step less
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_level_out     <= lpsc_pkg::LEVEL_FULL;
      adjust_active_out <= 1'b0;
    end else begin
      ref_level_out <= {1'b0, contrast_level_in} + lpsc_pkg::LEVEL_OFFSET;
      adjust_active_out <= !(supply_mode_pin_a_in && supply_mode_pin_b_in)
                           && supply_on_in;
    end
  end
endmodule : lpsc_contrast
`default_nettype wire

// [design/lpsc_ctrl.sv]
`default_nettype none
module lpsc_ctrl (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       parallel_select_in,
  input  wire logic       chip_select_n_in,
  input  wire logic       command_data_select_in,
  input  wire logic       write_strobe_in,
  input  wire logic       read_strobe_in,
  input  wire logic [7:0] bus_data_in,
  input  wire logic       serial_clock_rise_in,
  input  wire logic       serial_data_in,
  input  wire logic       bus_style_select_in,
  input  wire logic       supply_mode_pin_a_in,
  input  wire logic       supply_mode_pin_b_in,
  input  wire logic [7:0] contrast_level_in,
  output logic [7:0]      bus_data_out,
  output logic            bus_data_oe_out,
  output logic            instr_valid_out,
  output logic [7:0]      instr_out,
  output logic            data_valid_out,
  output logic [7:0]      data_out,
  output logic            power_save_out,
  output logic            osc_enable_out,
  output logic            supply_enable_out,
  output logic            drive_enable_out,
  output logic            outputs_at_vdd_out,
  output logic            bias_at_vdd_out,
  output logic            display_on_out,
  output logic            segment_output_reverse_out,
  output logic [8:0]      ref_level_out,
  output logic            contrast_active_out
);
  function automatic logic op_hit(input logic [7:0] b, input logic [7:0] op,
                                  input logic [7:0] m);
    op_hit = (b & m) == op;
  endfunction : op_hit

  logic       ser_strobe;
  logic       ser_cds;
  logic [7:0] ser_data;
  logic       par_write;
  logic       wr_valid;
  logic       wr_cds;
  logic [7:0] wr_byte;
  logic       is_instr;
  logic       disp_off_q;
  logic       whole_on_q;
  logic       drive_q;
  logic       supply_q;
  logic       col_rev_q;
  logic       power_save;

  lpsc_serial_rx #(.BITS(lpsc_pkg::SER_BITS)) u_serial (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .sel_n_in    (chip_select_n_in | parallel_select_in),
    .sck_rise_in (serial_clock_rise_in),
    .sdi_in      (serial_data_in),
    .cds_in      (command_data_select_in),
    .strobe_out  (ser_strobe),
    .cds_out     (ser_cds),
    .data_out    (ser_data)
  );

  // bus style only renames strobes and shows in readback bit 1; both arrive as write/read pulses
  assign par_write = parallel_select_in && !chip_select_n_in
                     && write_strobe_in;
  assign wr_valid  = parallel_select_in ? par_write : ser_strobe;
  assign wr_cds    = parallel_select_in ? command_data_select_in : ser_cds;
  assign wr_byte   = parallel_select_in ? bus_data_in : ser_data;
  assign is_instr  = wr_valid && !wr_cds;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      instr_valid_out <= 1'b0;
      instr_out       <= 8'h00;
      data_valid_out  <= 1'b0;
      data_out        <= 8'h00;
    end else begin
      instr_valid_out <= is_instr;
      data_valid_out  <= wr_valid && wr_cds;
      if (wr_valid) begin
        instr_out <= wr_cds ? instr_out : wr_byte;
        data_out  <= wr_cds ? wr_byte : data_out;
      end
    end
  end

  // display-off and whole-display-on flags
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      disp_off_q <= 1'b1;
      whole_on_q <= 1'b0;
    end else if (is_instr) begin
      if (op_hit(wr_byte, lpsc_pkg::OP_DISP_ONOFF, lpsc_pkg::OP_DISP_MASK))
        disp_off_q <= !wr_byte[0];
      if (op_hit(wr_byte, lpsc_pkg::OP_WHOLE_ONOFF, lpsc_pkg::OP_WHOLE_MASK))
        whole_on_q <= wr_byte[0];
    end
  end

  assign power_save = disp_off_q && whole_on_q;

  // supply and segment order survive power save untouched; drive is cleared in every power-save cycle that does not write a drive instruction
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive_q   <= 1'b0;
      supply_q  <= 1'b0;
      col_rev_q <= 1'b0;
    end else if (is_instr) begin
      if (op_hit(wr_byte, lpsc_pkg::OP_DRIVE, lpsc_pkg::OP_DRIVE_MASK))
        drive_q <= wr_byte[0];
      else if (power_save)
        drive_q <= 1'b0;
      if (op_hit(wr_byte, lpsc_pkg::OP_SUPPLY, lpsc_pkg::OP_SUPPLY_MASK))
        supply_q <= wr_byte[0];
      if (op_hit(wr_byte, lpsc_pkg::OP_COL_ORDER, lpsc_pkg::OP_COL_MASK))
        col_rev_q <= wr_byte[0];
    end else if (power_save) begin
      drive_q <= 1'b0;
    end
  end

  assign power_save_out             = power_save;
  assign osc_enable_out             = !power_save;
  assign supply_enable_out          = supply_q && !power_save;
  assign drive_enable_out           = drive_q && !power_save;
  assign outputs_at_vdd_out         = !drive_enable_out;
  assign bias_at_vdd_out            = power_save;
  assign display_on_out             = !disp_off_q;
  assign segment_output_reverse_out = col_rev_q;

  // readback only in parallel mode
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_data_out    <= 8'h00;
      bus_data_oe_out <= 1'b0;
    end else begin
      bus_data_oe_out <= parallel_select_in && !chip_select_n_in
                         && read_strobe_in;
      bus_data_out    <= {power_save, disp_off_q, whole_on_q, drive_q,
                          supply_q, col_rev_q, bus_style_select_in, 1'b0};
    end
  end

  lpsc_contrast u_contrast (
    .clock_in             (clock_in),
    .rst_n_in             (rst_n_in),
    .contrast_level_in    (contrast_level_in),
    .supply_mode_pin_a_in (supply_mode_pin_a_in),
    .supply_mode_pin_b_in (supply_mode_pin_b_in),
    .supply_on_in         (supply_enable_out),
    .ref_level_out        (ref_level_out),
    .adjust_active_out    (contrast_active_out)
  );
endmodule : lpsc_ctrl
`default_nettype wire

// [tb/lpsc_ctrl_checker.sv]
`default_nettype none
module lpsc_ctrl_checker (
  input wire logic       clock_in, rst_n_in, parallel_select_in,
  input wire logic       chip_select_n_in, command_data_select_in,
  input wire logic       write_strobe_in, supply_mode_pin_a_in,
  input wire logic       supply_mode_pin_b_in, bus_data_oe_out,
  input wire logic       instr_valid_out, power_save_out, osc_enable_out,
  input wire logic       supply_enable_out, outputs_at_vdd_out,
  input wire logic       bias_at_vdd_out, display_on_out,
  input wire logic       segment_output_reverse_out, contrast_active_out,
  input wire logic [7:0] bus_data_in, contrast_level_in, instr_out,
  input wire logic [8:0] ref_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire logic wi = write_strobe_in & !chip_select_n_in & parallel_select_in
    & !command_data_select_in;
  save_off_a: assert property (power_save_out |-> !display_on_out)
    else $error("save with display on");
  save_entry_a: assert property (wi && bus_data_in == 8'hA5
    && !display_on_out |=> power_save_out) else $error("no save entry");
  save_state_a: assert property (power_save_out |-> !osc_enable_out
    && !supply_enable_out && outputs_at_vdd_out && bias_at_vdd_out)
    else $error("save state wrong");
  save_exit_a: assert property (wi && bus_data_in == 8'hA4
    |=> !power_save_out) else $error("no save exit");
  drive_hold_a: assert property ($fell(power_save_out)
    |-> outputs_at_vdd_out) else $error("outputs not held");
  seg_order_a: assert property (wi && bus_data_in[7:1] == 7'h50
    |=> segment_output_reverse_out == $past(bus_data_in[0]))
    else $error("segment order wrong");
  level_map_a: assert property ($past(rst_n_in) |-> ref_level_out
    == {1'b0, $past(contrast_level_in)} + 9'h02D) else $error("bad level");
  supply_pins_a: assert property ($past(rst_n_in
    && supply_mode_pin_a_in && supply_mode_pin_b_in)
    |-> !contrast_active_out) else $error("contrast active");
  instr_take_a: assert property (wi |=> instr_valid_out
    && instr_out == $past(bus_data_in)) else $error("instruction lost");
  no_readback_a: assert property ($past(rst_n_in
    && !parallel_select_in) |-> !bus_data_oe_out) else $error("serial read");
  cover property (power_save_out);
  cover property ($fell(power_save_out));
  cover property (contrast_active_out);
endmodule : lpsc_ctrl_checker
`default_nettype wire

// [tb/lpsc_host.sv]
`default_nettype none
module lpsc_host (
  input  wire logic      clock_in,
  output var logic       par_out, csn_out, cds_out, wr_out, rd_out,
  output var logic       sck_out, sdi_out,
  output var logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {par_out, csn_out, cds_out, wr_out, rd_out, sck_out, sdi_out,
    data_out} = 15'h6000;
  // one byte; released data shows the inverse of the last value
  task automatic put(input logic ser, c, r, input logic [7:0] b);
    @(negedge clock_in);
    {par_out, csn_out, cds_out, rd_out} <= {!ser, 1'b0, c, r};
    if (!ser) begin
      {data_out, wr_out} <= {b, !r};
      @(negedge clock_in);
    end else
      for (int i = 7; i >= 0; i--) begin
        {sdi_out, sck_out} <= {b[i], 1'b1};
        @(negedge clock_in);
        sck_out <= 1'b0;
        @(negedge clock_in);
      end
    {wr_out, rd_out, csn_out, data_out, sdi_out} <= {3'h1, ~b, ~b[0]};
  endtask : put
endmodule : lpsc_host
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, rst_n_in, parallel_select_in, chip_select_n_in;
  logic command_data_select_in, write_strobe_in, read_strobe_in;
  logic serial_clock_rise_in, serial_data_in, bus_style_select_in;
  logic supply_mode_pin_a_in, supply_mode_pin_b_in, bus_data_oe_out;
  logic instr_valid_out, data_valid_out, power_save_out, osc_enable_out;
  logic supply_enable_out, drive_enable_out, outputs_at_vdd_out;
  logic bias_at_vdd_out, display_on_out, segment_output_reverse_out;
  logic contrast_active_out, doff, won, drv, sup, rvs, p;
  logic [7:0] bus_data_in, contrast_level_in, bus_data_out, instr_out;
  logic [7:0] data_out;
  logic [8:0] ref_level_out;
  logic [31:0] x;
  int n_fail, n_compared;
  logic [7:0] seq [17] = '{8'hAF, 8'hA5, 8'hAE, 8'hA4, 8'h25, 8'h23,
    8'hA1, 8'hAE, 8'hA5, 8'hA4, 8'hAF, 8'h23, 8'h22, 8'hA1, 8'h24,
    8'hAE, 8'hA5};
  lpsc_ctrl i_lpsc_ctrl (.*);
  lpsc_host i_lpsc_host (.clock_in, .par_out(parallel_select_in),
    .csn_out(chip_select_n_in), .cds_out(command_data_select_in),
    .wr_out(write_strobe_in), .rd_out(read_strobe_in),
    .sck_out(serial_clock_rise_in), .sdi_out(serial_data_in),
    .data_out(bus_data_in));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  task automatic chk(input logic [8:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic rst();
    rst_n_in = 1'b0;
    {doff, won, drv, sup, rvs} = 5'h10;
    repeat (3) @(negedge clock_in);
    chk({power_save_out, osc_enable_out}, 9'h001);
    chk(segment_output_reverse_out, 9'h000);
    chk(ref_level_out, 9'h12C);
    rst_n_in = 1'b1;
  endtask : rst
  task automatic op(input logic s, c, r, input logic [7:0] b);
    logic [31:0] v;
    logic w;
    v = rnd();
    w = !(r && !s);
    {supply_mode_pin_a_in, supply_mode_pin_b_in, bus_style_select_in} = v[2:0];
    contrast_level_in = 8'h37 + v[15:8] % 8'hC9;
    i_lpsc_host.put(s, c, r, b);
    if (!c && w)
      case (b[7:1])
        7'h57: doff = !b[0];
        7'h52: won = b[0];
        7'h50: rvs = b[0];
        7'h11: drv = b[0];
        7'h12: sup = b[0];
        default: ;
      endcase
    p = doff & won;
    if (p) drv = 1'b0;
    if (w) chk(c ? {data_valid_out, data_out}
      : {instr_valid_out, instr_out}, {1'b1, b});
    chk(bus_data_oe_out, !w);
    if (!w)
      chk(bus_data_out, {p, doff, won, drv, sup, rvs, v[0], 1'b0});
    @(negedge clock_in);
    chk({power_save_out, osc_enable_out, supply_enable_out,
      outputs_at_vdd_out, bias_at_vdd_out, display_on_out,
      segment_output_reverse_out, drive_enable_out},
      {p, !p, sup && !p, !(drv && !p), p, !doff, rvs, drv && !p});
    chk(ref_level_out, 9'h12C - (9'h0FF - contrast_level_in));
    chk(contrast_active_out, !(v[2] && v[1]) && sup && !p);
  endtask : op
  initial begin
    {x, n_fail, n_compared, contrast_level_in} = {32'h55, 64'h0, 8'hFF};
    {supply_mode_pin_a_in, supply_mode_pin_b_in, bus_style_select_in} = 3'h0;
    rst();
    for (int m = 0; m < 2; m++)
      foreach (seq[i]) op(m[0], 1'b0, 1'b0, seq[i]);
    for (int m = 0; m < 4; m++) begin
      op(m[0], 1'b1, 1'b0, 8'(rnd()));
      op(m[0], 1'b0, 1'b1, 8'hE3);
    end
    rst();
    op(1'b0, 1'b0, 1'b1, 8'h00);
    give_verdict();
  end
  initial begin
    #50us;
    n_fail++;
    give_verdict();
  end
endmodule : testbench
bind lpsc_ctrl lpsc_ctrl_checker i_lpsc_ctrl_checker (.*);
`default_nettype wire
